// ### gps_port.sv
// Contract
// - Two port interrupts, each with own pin set, silent until software enables it.
// - Synchronous sensing supports rising, falling, both edges and low level.
// - Synchronous edge raises request only after new value sampled once.
// - Pin 2 latches any selected edge in sleep and always raises request.
// - Other pins in sleep: both edges or low only; reverted change wakes silently.
// - Low level detected with or without clock; request holds while low.
// - Low level must last through wake-up or no request follows.
// - Events only while peripheral clock runs; edge needs one sample.
// - Level sensing: no event while low, event every clock while high.
// - Enabled peripheral overrides direction and value via hidden signals.
// - Peripheral clock or event channel 0 routed to selectable pin.
// - Multi-pin mask makes one config write update all masked pins.
// - Four virtual port windows behave exactly like real registers.
// - Eight-bit direction register; one means output.
// - Direction-set alias sets written ones; reads direction.
// - Direction-clear alias clears written ones; reads direction.
// - Direction-toggle alias inverts written ones; reads direction.
// - Pin driven from output-value bit only while direction is output.
// - Output-set alias sets written ones; reads output value.
// - Output-clear alias clears written ones; reads output value.
// - Sense codes: both, rising, falling, low, reserved, input disable.
// - Interrupt source masks select contributing pins per interrupt.
// - Flag sets on masked sense match; cleared by writing one.
// - Output-toggle alias inverts written ones; reads output value.
`default_nettype none
module gps_port (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Port pins
   input wire logic [7:0] PIN_I,
   output logic [7:0] PIN_O,
   output logic [7:0] PIN_OE_N,
   // Peripheral side
   input wire logic PCLK_RUN,
   input wire gps_pkg::gps_ovr_t OVR,
   input wire logic EVCH0,
   output logic [7:0] EVT_OUT,
   output logic [1:0] IRQ,
   output logic WAKE_REQ
);
   import gps_pkg::*;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic edge_hit(input logic [2:0] sns, input logic prv, input logic cur);
      edge_hit = ((sns == GPS_SNS_BOTH) && (prv != cur)) ||
                 ((sns == GPS_SNS_RISE) && !prv && cur) ||
                 ((sns == GPS_SNS_FALL) && prv && !cur);
   endfunction : edge_hit

   function automatic logic [7:0] remap(input logic [7:0] a, input logic [3:0] vp);
      logic [7:0] r;
      r = a;
      if (a[7] && !a[6] && vp[a[5:4]]) begin
         case (a[3:2])
            2'h0: r = GPS_OFS_DIR;
            2'h1: r = GPS_OFS_LVL;
            2'h2: r = GPS_OFS_PINVAL;
            default: r = GPS_OFS_IRQFLG;
         endcase
      end
      remap = r;
   endfunction : remap

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   gps_bus_state_t bus_q;
   logic [7:0] addr_q;
   logic wr_q;
   logic [31:0] rdata_q;
   logic ready_q;
   logic [7:0] dir_q;
   logic [7:0] lvl_q;
   logic [3:0] irqctl_q;
   logic [7:0] msk0_q;
   logic [7:0] msk1_q;
   logic [1:0] flag_q;
   logic [7:0] mpc_q;
   logic [4:0] osel_q;
   logic [3:0] vp_q;
   gps_pin_cfg_t cfg_q [8];
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] prev_q;
   logic [7:0] snap_q;
   logic [7:0] lat_q;
   logic run_q;
   logic wake_q;
   logic clk_tog_q;
   logic evch_q;
   logic [7:0] pin_o_q;
   logic [7:0] pin_oe_n_q;
   logic [7:0] evt_q;
   logic [1:0] irq_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire take = HSEL && HTRANS[1] && HREADY;
   wire [7:0] eff = remap(addr_q, vp_q);
   wire wr_now = (bus_q == GPS_BUS_WAIT) && wr_q;
   wire [7:0] wdat = HWDATA[7:0];
   wire wr_dir = wr_now && (eff == GPS_OFS_DIR);
   wire wr_dset = wr_now && (eff == GPS_OFS_DIRECTION_SET);
   wire wr_dclr = wr_now && (eff == GPS_OFS_DIRECTION_CLEAR);
   wire wr_dtgl = wr_now && (eff == GPS_OFS_DIRECTION_TOGGLE);
   wire wr_lvl = wr_now && (eff == GPS_OFS_LVL);
   wire wr_lset = wr_now && (eff == GPS_OFS_LVLSET);
   wire wr_lclr = wr_now && (eff == GPS_OFS_LVLCLR);
   wire wr_ltgl = wr_now && (eff == GPS_OFS_LVLTGL);
   wire wr_flag = wr_now && (eff == GPS_OFS_IRQFLG);
   wire wr_cfg = wr_now && (eff[7:5] == GPS_OFS_PINCFG[7:5]) && (eff[1:0] == 2'h0);
   wire [2:0] cfg_idx = eff[4:2];

   // Aliases only modify bits written as one; plain writes replace the byte.
   wire [7:0] dir_d = wr_dir ? wdat :
                      wr_dset ? (dir_q | wdat) :
                      wr_dclr ? (dir_q & ~wdat) :
                      wr_dtgl ? (dir_q ^ wdat) : dir_q;
   wire [7:0] lvl_d = wr_lvl ? wdat :
                      wr_lset ? (lvl_q | wdat) :
                      wr_lclr ? (lvl_q & ~wdat) :
                      wr_ltgl ? (lvl_q ^ wdat) : lvl_q;

   // ----------------------------------------------------------------
   // Input sensing
   // ----------------------------------------------------------------
   logic [7:0] cur_v;
   logic [7:0] prv_v;
   logic [7:0] inoff;
   logic [7:0] inv;
   logic [7:0] sync_hit;
   logic [7:0] wake_src;
   logic [7:0] wake_hit;
   logic [7:0] lat_set;
   logic [7:0] evt_d;
   wire wake_end = PCLK_RUN && !run_q;
   wire [1:0] irq_en = {|irqctl_q[3:2], |irqctl_q[1:0]};

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         wire [2:0] sns = cfg_q[g].sense_select;
         wire lvl_sns = (sns == GPS_SNS_LOW);
         assign inv[g] = cfg_q[g].invert_io_enable;
         assign inoff[g] = (sns == GPS_SNS_INOFF);
         assign cur_v[g] = (sync2_q[g] ^ inv[g]) && !inoff[g];
         assign prv_v[g] = (prev_q[g] ^ inv[g]) && !inoff[g];
         // Edges compare two synchronised samples, so a change is seen only once
         // it has been captured by the clock.
         assign sync_hit[g] = PCLK_RUN && (edge_hit(sns, prv_v[g], cur_v[g]) ||
                                           (lvl_sns && !cur_v[g]));
         // Events follow the pin value: high level streams events, low does not.
         assign evt_d[g] = PCLK_RUN && (edge_hit(sns, prv_v[g], cur_v[g]) ||
                                        (lvl_sns && cur_v[g]));
         if (g == GPS_FULL_ASYNC_PIN) begin : g_full
            assign lat_set[g] = !PCLK_RUN && edge_hit(sns, prv_v[g], cur_v[g]);
            assign wake_src[g] = lat_set[g] || lat_q[g] || (lvl_sns && !cur_v[g]);
            assign wake_hit[g] = wake_end && lat_q[g];
         end else begin : g_lim
            wire both = (sns == GPS_SNS_BOTH);
            assign lat_set[g] = 1'b0;
            assign wake_src[g] = (both && (cur_v[g] != snap_q[g])) ||
                                 (lvl_sns && !cur_v[g]);
            // A change that reverted during wake-up leaves no request.
            assign wake_hit[g] = wake_end && both && (cur_v[g] != snap_q[g]);
         end
      end
   endgenerate

   wire [7:0] src0 = msk0_q;
   wire [7:0] src1 = msk1_q;
   wire [7:0] hit = sync_hit | wake_hit;
   wire [1:0] flag_set = {|(hit & src1), |(hit & src0)};
   wire [1:0] flag_clr = wr_flag ? wdat[1:0] : 2'h0;
   // A new match in the clearing cycle keeps the flag set.
   wire [1:0] flag_d = (flag_q & ~flag_clr) | flag_set;
   wire wake_any = |((src0 & {8{irq_en[0]}} | src1 & {8{irq_en[1]}}) & wake_src);
   wire [1:0] irq_d = flag_q & irq_en;

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   wire [2:0] osel_pin = osel_q[GPS_OSEL_PIN_LSB +: 3];
   wire osel_clk = osel_q[GPS_OSEL_CLK_BIT];
   wire osel_evt = osel_q[GPS_OSEL_EVT_BIT];
   logic [7:0] drv_dir;
   logic [7:0] drv_val;
   generate
      for (g = 0; g < 8; g++) begin : g_drv
         wire route = (osel_clk || osel_evt) && (osel_pin == 3'(g));
         wire rval = osel_clk ? clk_tog_q : evch_q;
         wire base_dir = route ? 1'b1 : dir_q[g];
         wire base_val = route ? rval : (lvl_q[g] ^ inv[g]);
         assign drv_dir[g] = OVR.dir_en[g] ? OVR.dir[g] : base_dir;
         assign drv_val[g] = OVR.val_en[g] ? OVR.val[g] : base_val;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   logic [7:0] rd_byte;
   logic rd_hit;
   always_comb begin
      rd_byte = GPS_RST_BYTE;
      rd_hit = 1'b1;
      case (eff)
         GPS_OFS_DIR, GPS_OFS_DIRECTION_SET, GPS_OFS_DIRECTION_CLEAR, GPS_OFS_DIRECTION_TOGGLE: rd_byte = dir_q;
         GPS_OFS_LVL, GPS_OFS_LVLSET, GPS_OFS_LVLCLR, GPS_OFS_LVLTGL: rd_byte = lvl_q;
         GPS_OFS_PINVAL: rd_byte = cur_v;
         GPS_OFS_IRQCTL: rd_byte = {4'h0, irqctl_q};
         GPS_OFS_IRQ0MSK: rd_byte = msk0_q;
         GPS_OFS_IRQ1MSK: rd_byte = msk1_q;
         GPS_OFS_IRQFLG: rd_byte = {6'h00, flag_q};
         GPS_OFS_MPCMSK: rd_byte = mpc_q;
         GPS_OFS_OUTSEL: rd_byte = {3'h0, osel_q};
         GPS_OFS_VPCTL: rd_byte = {4'h0, vp_q};
         default: rd_hit = 1'b0;
      endcase
      if (wr_cfg || (!wr_q && (eff[7:5] == GPS_OFS_PINCFG[7:5]) && (eff[1:0] == 2'h0))) begin
         rd_byte = {1'b0, cfg_q[cfg_idx].invert_io_enable, 3'h0, cfg_q[cfg_idx].sense_select};
         rd_hit = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Bus slave: one wait state, so read data comes from a register.
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         bus_q <= GPS_BUS_IDLE;
         addr_q <= GPS_RST_BYTE;
         wr_q <= 1'b0;
         ready_q <= 1'b1;
         rdata_q <= GPS_RD_NONE;
      end else begin
         case (bus_q)
            GPS_BUS_IDLE: begin
               if (take) begin
                  bus_q <= GPS_BUS_WAIT;
                  addr_q <= {HADDR[7:2], 2'h0};
                  wr_q <= HWRITE;
                  ready_q <= 1'b0;
               end
            end
            GPS_BUS_WAIT: begin
               bus_q <= GPS_BUS_IDLE;
               ready_q <= 1'b1;
               rdata_q <= (!wr_q && rd_hit) ? {24'h000000, rd_byte} : GPS_RD_NONE;
            end
            default: bus_q <= GPS_BUS_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         dir_q <= GPS_RST_BYTE;
         lvl_q <= GPS_RST_BYTE;
         irqctl_q <= 4'h0;
         msk0_q <= GPS_RST_BYTE;
         msk1_q <= GPS_RST_BYTE;
         flag_q <= 2'h0;
         mpc_q <= GPS_RST_BYTE;
         osel_q <= 5'h00;
         vp_q <= 4'h0;
      end else begin
         dir_q <= dir_d;
         lvl_q <= lvl_d;
         flag_q <= flag_d;
         if (wr_now && (eff == GPS_OFS_IRQCTL)) irqctl_q <= wdat[3:0];
         if (wr_now && (eff == GPS_OFS_IRQ0MSK)) msk0_q <= wdat;
         if (wr_now && (eff == GPS_OFS_IRQ1MSK)) msk1_q <= wdat;
         if (wr_now && (eff == GPS_OFS_OUTSEL)) osel_q <= wdat[4:0];
         if (wr_now && (eff == GPS_OFS_VPCTL)) vp_q <= wdat[3:0];
         // The mask is consumed by the next pin config write.
         if (wr_cfg) begin
            mpc_q <= GPS_RST_BYTE;
         end else if (wr_now && (eff == GPS_OFS_MPCMSK)) begin
            mpc_q <= wdat;
         end
      end
   end

   generate
      for (g = 0; g < 8; g++) begin : g_cfg
         wire sel = (mpc_q != GPS_RST_BYTE) ? mpc_q[g] : (cfg_idx == 3'(g));
         always_ff @(posedge SYS_CLK) begin
            if (SYS_RST) begin
               cfg_q[g] <= '0;
            end else if (wr_cfg && sel) begin
               cfg_q[g] <= {wdat[GPS_CFG_INV_BIT], wdat[2:0]};
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Sensing, wake-up and pin outputs
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         sync1_q <= GPS_RST_BYTE;
         sync2_q <= GPS_RST_BYTE;
         prev_q <= GPS_RST_BYTE;
         snap_q <= GPS_RST_BYTE;
         lat_q <= GPS_RST_BYTE;
         run_q <= 1'b0;
         wake_q <= 1'b0;
         clk_tog_q <= 1'b0;
         evch_q <= 1'b0;
         pin_o_q <= GPS_RST_BYTE;
         pin_oe_n_q <= 8'hFF;
         evt_q <= GPS_RST_BYTE;
         irq_q <= 2'h0;
      end else begin
         sync1_q <= PIN_I;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         run_q <= PCLK_RUN;
         // The last clocked value is the reference for a change during sleep.
         if (PCLK_RUN) snap_q <= cur_v;
         lat_q <= wake_end ? GPS_RST_BYTE : (lat_q | lat_set);
         wake_q <= PCLK_RUN ? 1'b0 : (wake_q | wake_any);
         clk_tog_q <= osel_clk ? ~clk_tog_q : 1'b0;
         evch_q <= EVCH0;
         pin_o_q <= drv_val;
         pin_oe_n_q <= ~drv_dir;
         evt_q <= evt_d;
         irq_q <= irq_d;
      end
   end

   assign HRDATA = rdata_q;
   assign HREADYOUT = ready_q;
   assign HRESP = 1'b0;
   assign PIN_O = pin_o_q;
   assign PIN_OE_N = pin_oe_n_q;
   assign EVT_OUT = evt_q;
   assign IRQ = irq_q;
   assign WAKE_REQ = wake_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_data_phase;
      !HREADYOUT ##1 HREADYOUT;
   endsequence

   property p_bus_wait;
      @(posedge SYS_CLK) disable iff (SYS_RST) take |=> s_data_phase;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("Data phase length wrong.");

   property p_irq_gate;
      @(posedge SYS_CLK) disable iff (SYS_RST) !irq_en[0] |=> !IRQ[0];
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("Interrupt 0 raised while off.");

   property p_direction_set;
      @(posedge SYS_CLK) disable iff (SYS_RST)
         wr_dset |=> dir_q == ($past(dir_q) | $past(HWDATA[7:0]));
   endproperty
   a_direction_set: assert property (p_direction_set) else $error("Direction set alias wrong.");

   property p_direction_clear;
      @(posedge SYS_CLK) disable iff (SYS_RST)
         wr_dclr |=> dir_q == ($past(dir_q) & ~$past(HWDATA[7:0]));
   endproperty
   a_direction_clear: assert property (p_direction_clear) else $error("Direction clear alias wrong.");

   property p_lvltgl;
      @(posedge SYS_CLK) disable iff (SYS_RST)
         wr_ltgl |=> lvl_q == ($past(lvl_q) ^ $past(HWDATA[7:0]));
   endproperty
   a_lvltgl: assert property (p_lvltgl) else $error("Output toggle alias wrong.");

   property p_flag_set_wins;
      @(posedge SYS_CLK) disable iff (SYS_RST)
         flag_set[0] |=> flag_q[0] ##1 (IRQ[0] == $past(irq_en[0]));
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) else $error("Interrupt flag lost.");

   property p_no_evt_sleep;
      @(posedge SYS_CLK) disable iff (SYS_RST) !PCLK_RUN |=> EVT_OUT == 8'h00;
   endproperty
   a_no_evt_sleep: assert property (p_no_evt_sleep) else $error("Event without clock.");

   property p_level_evt;
      @(posedge SYS_CLK) disable iff (SYS_RST)
         PCLK_RUN && (cfg_q[0].sense_select == GPS_SNS_LOW) |=> EVT_OUT[0] == $past(cur_v[0]);
   endproperty
   a_level_evt: assert property (p_level_evt) else $error("Level event wrong.");

   property p_mpc_clear;
      @(posedge SYS_CLK) disable iff (SYS_RST) wr_cfg |=> mpc_q == 8'h00;
   endproperty
   a_mpc_clear: assert property (p_mpc_clear) else $error("Multi-pin mask kept.");

   property p_drive;
      @(posedge SYS_CLK) disable iff (SYS_RST)
         !OVR.dir_en[0] && !osel_clk && !osel_evt |=> PIN_OE_N[0] == !$past(dir_q[0]);
   endproperty
   a_drive: assert property (p_drive) else $error("Pin 0 direction wrong.");
endmodule : gps_port
`default_nettype wire

// ### gps_pkg.sv
`default_nettype none
package gps_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] GPS_OFS_DIR = 8'h00;
   localparam logic [7:0] GPS_OFS_DIRECTION_SET = 8'h04;
   localparam logic [7:0] GPS_OFS_DIRECTION_CLEAR = 8'h08;
   localparam logic [7:0] GPS_OFS_DIRECTION_TOGGLE = 8'h0C;
   localparam logic [7:0] GPS_OFS_LVL = 8'h10;
   localparam logic [7:0] GPS_OFS_LVLSET = 8'h14;
   localparam logic [7:0] GPS_OFS_LVLCLR = 8'h18;
   localparam logic [7:0] GPS_OFS_LVLTGL = 8'h1C;
   localparam logic [7:0] GPS_OFS_PINVAL = 8'h20;
   localparam logic [7:0] GPS_OFS_IRQCTL = 8'h24;
   localparam logic [7:0] GPS_OFS_IRQ0MSK = 8'h28;
   localparam logic [7:0] GPS_OFS_IRQ1MSK = 8'h2C;
   localparam logic [7:0] GPS_OFS_IRQFLG = 8'h30;
   localparam logic [7:0] GPS_OFS_MPCMSK = 8'h34;
   localparam logic [7:0] GPS_OFS_OUTSEL = 8'h38;
   localparam logic [7:0] GPS_OFS_VPCTL = 8'h3C;
   localparam logic [7:0] GPS_OFS_PINCFG = 8'h40;
   localparam logic [7:0] GPS_OFS_VPBASE = 8'h80;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int GPS_CFG_INV_BIT = 6;
   localparam int GPS_OSEL_CLK_BIT = 0;
   localparam int GPS_OSEL_EVT_BIT = 1;
   localparam int GPS_OSEL_PIN_LSB = 2;
   localparam logic [7:0] GPS_RST_BYTE = 8'h00;
   localparam logic [31:0] GPS_RD_NONE = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Sense selection codes
   // ----------------------------------------------------------------
   localparam logic [2:0] GPS_SNS_BOTH = 3'h0;
   localparam logic [2:0] GPS_SNS_RISE = 3'h1;
   localparam logic [2:0] GPS_SNS_FALL = 3'h2;
   localparam logic [2:0] GPS_SNS_LOW = 3'h3;
   localparam logic [2:0] GPS_SNS_INOFF = 3'h7;
   localparam int GPS_FULL_ASYNC_PIN = 2;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic invert_io_enable;
      logic [2:0] sense_select;
   } gps_pin_cfg_t;
   typedef struct packed {
      logic [7:0] dir_en;
      logic [7:0] dir;
      logic [7:0] val_en;
      logic [7:0] val;
   } gps_ovr_t;
   typedef enum logic {
      GPS_BUS_IDLE = 1'b0,
      GPS_BUS_WAIT = 1'b1
   } gps_bus_state_t;
endpackage : gps_pkg
`default_nettype wire

// ### gps_pins_model.sv
`default_nettype none
module gps_pins_model (
   // Port side of the pins
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_n,
   // Outside driver and resulting levels
   input wire logic [7:0] ext,
   output logic [7:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // A driven pin reads back its own level; a released one follows the outside driver.
   assign pin_i = (pin_o & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : gps_pins_model
`default_nettype wire

// ### gps_port_sense_and_control_bench.sv
`default_nettype none
module gps_port_sense_and_control_bench;
   import gps_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, hwrite, hready, hresp;
   logic [1:0] htrans, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0] ext, pin_i, pin_o, pin_oe_n, evt;
   logic [7:0] regs [2];
   logic [2:0] codes [4];
   logic e0, pclk, wake;
   int miscompares, samples_checked;
   gps_port gps_port_i (.SYS_CLK(clk), .SYS_RST(rst), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .PIN_I(pin_i), .PIN_O(pin_o),
      .PIN_OE_N(pin_oe_n), .PCLK_RUN(pclk), .OVR('0), .EVCH0(1'b0), .EVT_OUT(evt),
      .IRQ(irq), .WAKE_REQ(wake));
   gps_pins_model gps_pins_model_i (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext(ext),
      .pin_i(pin_i));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask : chk
   // The master holds each phase until hready is sampled high at a rising edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h00, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : bus
   task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : expect_rd
   function automatic logic [7:0] alias_next(input logic [7:0] c, input int op,
      input logic [7:0] w);
      case (op)
         0: return w;
         1: return c | w;
         2: return c & ~w;
         default: return c ^ w;
      endcase
   endfunction : alias_next
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   // Watchdog allows many times the few hundred cycles the tests need.
   initial begin
      #400000;
      miscompares++;
      finish_test();
   end
   initial begin
      int k;
      logic [31:0] w;
      rst = 1'b1;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      ext = 8'h00;
      pclk = 1'b1;
      codes = '{GPS_SNS_BOTH, GPS_SNS_RISE, GPS_SNS_FALL, GPS_SNS_LOW};
      regs = '{8'h00, 8'h00};
      void'($urandom(82225));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("released pins", 32'hFF, pin_oe_n);
      expect_rd(8'hF0, 32'h0, "unmapped read");
      for (int i = 0; i < 24; i++) begin
         k = i % 8;
         w = (i < 8) ? 32'hFFFF_FFFF : $urandom;
         bus(1'b1, 8'(4 * k), w);
         regs[k / 4] = alias_next(regs[k / 4], k % 4, w[7:0]);
         expect_rd(8'(4 * k), {24'h0, regs[k / 4]}, "alias readback");
      end
      repeat (2) @(posedge clk);
      chk("pin enables", {24'h0, ~regs[0]}, pin_oe_n);
      chk("pin drive", regs[0] & regs[1], pin_o & regs[0]);
      chk("bus response", 32'h0, hresp);
      $display("test registers done");
      bus(1'b1, GPS_OFS_DIR, 32'h0);
      bus(1'b1, GPS_OFS_IRQ0MSK, 32'h1);
      bus(1'b1, GPS_OFS_IRQ1MSK, 32'h2);
      bus(1'b1, GPS_OFS_IRQCTL, 32'h1);
      foreach (codes[c]) begin
         bus(1'b1, GPS_OFS_PINCFG, {29'h0, codes[c]});
         ext[0] <= 1'b1;
         repeat (8) @(posedge clk);
         bus(1'b1, GPS_OFS_IRQFLG, 32'h3);
         // Pin 0 falls while pin 1 toggles; the low is held well past capture.
         ext <= {ext[7:2], ~ext[1], 1'b0};
         repeat (8) @(posedge clk);
         e0 = (codes[c] != GPS_SNS_RISE);
         chk("irq lines", {30'h0, 1'b0, e0}, irq);
         chk("low event", 32'h0, evt[0]);
         expect_rd(GPS_OFS_IRQFLG, {30'h0, 1'b1, e0}, "irq flags");
         ext[0] <= 1'b1;
         repeat (8) @(posedge clk);
         bus(1'b1, GPS_OFS_IRQFLG, 32'h3);
         expect_rd(GPS_OFS_IRQFLG, 32'h0, "flags cleared");
         chk("high event", codes[c] == GPS_SNS_LOW, evt[0]);
      end
      $display("test sensing done");
      // Inverted low-level sensing turns a low pin into a stream of events.
      bus(1'b1, GPS_OFS_PINCFG, 32'h43);
      ext[0] <= 1'b0;
      repeat (6) @(posedge clk);
      chk("inverted event", 32'h1, evt[0]);
      // Sleep: pin 2 latches a rise, pin 3 changes and reverts before wake-up.
      bus(1'b1, GPS_OFS_IRQ0MSK, 32'h04);
      bus(1'b1, GPS_OFS_IRQ1MSK, 32'h08);
      bus(1'b1, GPS_OFS_IRQCTL, 32'h5);
      bus(1'b1, 8'(GPS_OFS_PINCFG + 8), {29'h0, GPS_SNS_RISE});
      bus(1'b1, GPS_OFS_IRQFLG, 32'h3);
      pclk <= 1'b0;
      ext[3:2] <= 2'h3;
      repeat (4) @(posedge clk);
      ext[3:2] <= 2'h0;
      repeat (6) @(posedge clk);
      chk("wake request", 32'h1, wake);
      chk("sleep events", 32'h0, evt);
      expect_rd(GPS_OFS_IRQFLG, 32'h0, "sleep flags");
      pclk <= 1'b1;
      repeat (4) @(posedge clk);
      expect_rd(GPS_OFS_IRQFLG, 32'h1, "wake flags");
      chk("wake dropped", 32'h0, wake);
      $display("test sleep done");
      finish_test();
   end
endmodule : gps_port_sense_and_control_bench
`default_nettype wire
